// ---- common/serial_fifo_consts.svh ----
// constants of the per-channel serial transmit and receive fifos
// assumes a 40 MHz APB clock; included by the package and the top module
`ifndef SERIAL_FIFO_CONSTS_SVH
`define SERIAL_FIFO_CONSTS_SVH

// fifo geometry
`define TXM_DEPTH      6
`define TXM_LAST       4'h5
`define TXM_FULL       3'h6
`define TX_REQ_MAXCNT  3'h2
`define RXM_LAST       4'hE
`define RXM_FULL       4'hF
`define SHADOW_FULL    2'h2

// register byte offsets
`define OFF_COMMAND    12'h000
`define OFF_CONFIG_0   12'h004
`define OFF_CONFIG_1   12'h008
`define OFF_CONFIG_2   12'h00C
`define OFF_STATUS     12'h010

// command bits
`define CMD_TX_RESET   0
`define CMD_RX_RESET   1
`define CMD_RX_FLUSH   2

// configuration fields
`define CFG0_POWER_UP  0
`define CFG1_TO_ENABLE 0
`define CFG1_TIMEOUT_LENGTH_LO  8
`define CFG2_RX_ACTIVE 0
`define CFG2_ASYNC     1
`define CFG2_RX_THRESHOLD_FIELD_LO   4

// status fields
`define STAT_RX_NE     0
`define STAT_TX_UNDER  1
`define STAT_RX_OVF    2
`define STAT_TXCNT_LO  8
`define STAT_RXCNT_LO  16

// receive thresholds in bytes
`define RX_THRESHOLD_FIELD_BYTES_0   6'h3C
`define RX_THRESHOLD_FIELD_BYTES_1   6'h20
`define RX_THRESHOLD_FIELD_BYTES_2   6'h10
`define RX_THRESHOLD_FIELD_BYTES_3   6'h08
`define RX_THRESHOLD_FIELD_BYTES_4   6'h04
`define RX_THRESHOLD_FIELD_BYTES_MIN 6'h01

// status byte overflow position, timeout unit of 16 clocks
`define RX_STATUS_BYTE_OVF_BIT   5
`define TIMEOUT_LENGTH_SHIFT    4'h0

`define REG_RESET      32'h0000_0000

`endif

// ---- common/serial_fifo_pkg.sv ----
// types shared by the serial channel fifo design
// assumes the constants header sits beside it
package serial_fifo_pkg;
`include "serial_fifo_consts.svh"

	typedef logic [31:0] dword_type;

	typedef struct packed {
		dword_type   data;
		logic [2:0]  bytes;
		logic        fe;
		logic [7:0]  status;
	} rx_entry_type;

endpackage

// ---- design/serial_fifo_mem.sv ----
// small word memory with registered read data
// assumes one write and one read port on the same clock
module serial_fifo_mem #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 6,
	parameter int AW    = 3
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// write port
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	// read port
	input  wire logic             rd_en,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] cells [DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			cells[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= '0;
		end else if (rd_en) begin
			rd_data <= cells[rd_addr];
		end
	end
endmodule

// ---- design/serial_channel_tx_rx_fifos.sv ----
// transmit and receive fifos of one serial channel, APB slave included
// assumes protocol-side strobes are already in the pclk domain
//
// The APB slave port and the placing of the registers were decided locally.
`include "serial_fifo_consts.svh"
module serial_channel_tx_rx_fifos
	import serial_fifo_pkg::*;
(
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// central transmit fifo side
	output logic             tx_fetch_req,
	input  wire logic        tx_fetch_valid,
	input  wire dword_type   tx_fetch_data,
	// transmit protocol side
	input  wire logic        tx_clk_present,
	input  wire logic        tx_send_allowed,
	input  wire logic        tx_underrun_evt,
	input  wire logic        tx_take,
	output dword_type        tx_word,
	output logic             tx_start,
	// receive protocol side
	input  wire logic        rx_word_valid,
	input  wire dword_type   rx_word,
	input  wire logic [2:0]  rx_word_bytes,
	input  wire logic        rx_word_frame_end,
	input  wire logic [7:0]  rx_word_status,
	output logic             rx_active,
	output logic             rx_proto_reset,
	output logic             rx_frame_lost,
	// central receive fifo side
	output logic             rx_store_req,
	input  wire logic        rx_store_pop,
	output logic             rx_store_valid,
	output dword_type        rx_store_data,
	output logic      [2:0]  rx_store_bytes,
	output logic             rx_store_frame_end,
	output logic      [7:0]  rx_store_status
);
	// ****************************************************
	// functions
	// ****************************************************
	function automatic logic [3:0] ptr_next(input logic [3:0] p,
		input logic [3:0] last);
		ptr_next = (p == last) ? 4'h0 : 4'(p + 4'h1);
	endfunction

	function automatic logic [5:0] rx_thresh(input logic [2:0] f);
		case (f)
			3'h0:    rx_thresh = `RX_THRESHOLD_FIELD_BYTES_0;
			3'h1:    rx_thresh = `RX_THRESHOLD_FIELD_BYTES_1;
			3'h2:    rx_thresh = `RX_THRESHOLD_FIELD_BYTES_2;
			3'h3:    rx_thresh = `RX_THRESHOLD_FIELD_BYTES_3;
			3'h4:    rx_thresh = `RX_THRESHOLD_FIELD_BYTES_4;
			default: rx_thresh = `RX_THRESHOLD_FIELD_BYTES_MIN;
		endcase
	endfunction

	// ****************************************************
	// registers and state
	// ****************************************************
	logic         power_up_bit;
	logic         timeout_enable;
	logic [7:0]   timeout_length;
	logic         async_mode;
	logic [2:0]   rx_threshold_field;
	logic         cmd_tx_rst;
	logic         cmd_rx_flush;
	logic         tx_underrun;
	logic         rx_overflow;
	logic [2:0]   txm_wp, txm_rp, txm_cnt;
	logic         txs_pend;
	dword_type    txs_e1;
	logic [1:0]   txs_cnt;
	logic [3:0]   rxm_wp, rxm_rp, rxm_cnt;
	logic [5:0]   rxm_bytes;
	logic [3:0]   rxm_fe_cnt;
	rx_entry_type rxs_e0, rxs_e1;
	logic [1:0]   rxs_cnt;
	logic         ovf_frame;
	logic         frame_stored;
	logic         flush_pend;
	logic [11:0]  idle_cnt;
	logic         idle_armed;
	logic         timeout_fire;
	dword_type    txm_rd;
	rx_entry_type rxm_rd;

	// ****************************************************
	// apb decode
	// ****************************************************
	wire setup    = psel & ~penable;
	wire wr_en    = psel & penable & pready & pwrite;
	wire hit_cmd  = (paddr == `OFF_COMMAND);
	wire hit_c0   = (paddr == `OFF_CONFIG_0);
	wire hit_c1   = (paddr == `OFF_CONFIG_1);
	wire hit_c2   = (paddr == `OFF_CONFIG_2);
	wire hit_stat = (paddr == `OFF_STATUS);
	wire mapped   = hit_cmd | hit_c0 | hit_c1 | hit_c2 | hit_stat;
	wire rx_rst   = rx_proto_reset;

	wire rx_not_empty = (rxs_cnt != 2'h0) | (rxm_cnt != 4'h0);

	wire [31:0] rd_c0 = 32'(power_up_bit);
	wire [31:0] rd_c1 = {16'h0000, timeout_length, 7'h00, timeout_enable};
	wire [31:0] rd_c2 = {25'h000_0000, rx_threshold_field, 2'h0,
		async_mode, rx_active};
	wire [31:0] rd_st = {12'h000, rxm_cnt, 5'h00, txm_cnt, 5'h00,
		rx_overflow, tx_underrun, rx_not_empty};
	wire [31:0] rd_mux = hit_c0 ? rd_c0 : hit_c1 ? rd_c1 :
		hit_c2 ? rd_c2 : hit_stat ? rd_st : 32'h0000_0000;

	// no wait state: answer prepared during setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= `REG_RESET;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~mapped;
			prdata  <= (setup & ~pwrite) ? rd_mux : `REG_RESET;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_up_bit       <= 1'b0;
			timeout_enable     <= 1'b0;
			timeout_length     <= 8'h00;
			rx_active          <= 1'b0;
			async_mode         <= 1'b0;
			rx_threshold_field <= 3'h0;
		end else if (wr_en) begin
			if (hit_c0) begin
				power_up_bit <= pwdata[`CFG0_POWER_UP];
			end
			if (hit_c1) begin
				timeout_enable <= pwdata[`CFG1_TO_ENABLE];
				timeout_length <= pwdata[`CFG1_TIMEOUT_LENGTH_LO +: 8];
			end
			if (hit_c2) begin
				rx_active          <= pwdata[`CFG2_RX_ACTIVE];
				async_mode         <= pwdata[`CFG2_ASYNC];
				rx_threshold_field <= pwdata[`CFG2_RX_THRESHOLD_FIELD_LO +: 3];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_tx_rst     <= 1'b0;
			rx_proto_reset <= 1'b0;
			cmd_rx_flush   <= 1'b0;
		end else begin
			cmd_tx_rst     <= wr_en & hit_cmd & pwdata[`CMD_TX_RESET];
			rx_proto_reset <= wr_en & hit_cmd & pwdata[`CMD_RX_RESET];
			cmd_rx_flush   <= wr_en & hit_cmd & pwdata[`CMD_RX_FLUSH];
		end
	end

	// ****************************************************
	// transmit path
	// ****************************************************
	// block stops intake
	wire tx_push  = tx_fetch_valid & (txm_cnt != `TXM_FULL) & ~tx_underrun
		& ~cmd_tx_rst;
	// one word in flight at a time
	wire tx_move  = (txm_cnt != 3'h0) & ~txs_pend & (txs_cnt != `SHADOW_FULL)
		& power_up_bit & tx_clk_present & ~tx_underrun & ~cmd_tx_rst;
	// no word to protocol while blocked
	wire txs_pop  = tx_take & (txs_cnt != 2'h0) & ~tx_underrun;
	wire txs_push = txs_pend & ~cmd_tx_rst;
	wire [1:0] txs_slot = 2'(txs_cnt - {1'b0, txs_pop});
	wire [2:0] next_txm_cnt = cmd_tx_rst ? 3'h0 :
		3'(txm_cnt + {2'h0, tx_push} - {2'h0, tx_move});
	wire [1:0] next_txs_cnt = cmd_tx_rst ? 2'h0 :
		2'(txs_slot + {1'b0, txs_push});
	// event sets, reset command clears, set wins
	wire next_tx_underrun = tx_underrun_evt | (tx_underrun & ~cmd_tx_rst);

	serial_fifo_mem #(.WIDTH(32), .DEPTH(`TXM_DEPTH), .AW(3)) tx_main (
		.clk     (pclk),
		.rst_n   (presetn),
		.wr_en   (tx_push),
		.wr_addr (txm_wp),
		.wr_data (tx_fetch_data),
		.rd_en   (tx_move),
		.rd_addr (txm_rp),
		.rd_data (txm_rd)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txm_wp      <= 3'h0;
			txm_rp      <= 3'h0;
			txm_cnt     <= 3'h0;
			txs_pend    <= 1'b0;
			tx_underrun <= 1'b0;
		end else begin
			txm_cnt     <= next_txm_cnt;
			txs_pend    <= tx_move;
			tx_underrun <= next_tx_underrun;
			if (cmd_tx_rst) begin
				txm_wp <= 3'h0;
				txm_rp <= 3'h0;
			end else begin
				if (tx_push) begin
					txm_wp <= 3'(ptr_next({1'b0, txm_wp}, `TXM_LAST));
				end
				if (tx_move) begin
					txm_rp <= 3'(ptr_next({1'b0, txm_rp}, `TXM_LAST));
				end
			end
		end
	end

	// two-word shadow part, head drives the protocol
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txs_cnt <= 2'h0;
			tx_word <= 32'h0000_0000;
			txs_e1  <= 32'h0000_0000;
		end else begin
			txs_cnt <= next_txs_cnt;
			if (txs_pop) begin
				tx_word <= txs_e1;
			end
			if (txs_push && txs_slot == 2'h0) begin
				tx_word <= txm_rd;
			end
			if (txs_push && txs_slot == 2'h1) begin
				txs_e1 <= txm_rd;
			end
		end
	end

	// request with four words free, power state ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_fetch_req <= 1'b0;
			tx_start     <= 1'b0;
		end else begin
			tx_fetch_req <= ~next_tx_underrun &
				(next_txm_cnt <= `TX_REQ_MAXCNT);
			// shadow word plus clock mode permission
			tx_start <= (next_txs_cnt != 2'h0) & tx_send_allowed &
				power_up_bit & ~next_tx_underrun;
		end
	end

	// ****************************************************
	// receive shadow part
	// ****************************************************
	// protocol side as pclk enables
	wire rx_in     = rx_word_valid & rx_active & ~rx_rst;
	wire rxs_pop   = (rxs_cnt != 2'h0) & (rxm_cnt != `RXM_FULL) & ~rx_rst;
	wire rxs_space = (rxs_cnt != `SHADOW_FULL) | rxs_pop;
	wire rx_accept = rx_in & rxs_space;
	wire rx_drop   = rx_in & ~rxs_space;
	// flush inserts a frame end, even with no data
	wire mark_in   = flush_pend & ~rx_in & rxs_space & ~rx_rst;
	wire rxs_push  = rx_accept | mark_in;
	wire lost      = rx_drop & rx_word_frame_end & ~frame_stored;
	wire [1:0] rxs_slot = 2'(rxs_cnt - {1'b0, rxs_pop});
	wire [7:0] ovf_mask = ovf_frame ? 8'(1 << `RX_STATUS_BYTE_OVF_BIT) : 8'h00;

	rx_entry_type push_ent;
	assign push_ent.data   = rx_accept ? rx_word : 32'h0000_0000;
	assign push_ent.bytes  = rx_accept ? rx_word_bytes : 3'h0;
	assign push_ent.fe     = rx_accept ? rx_word_frame_end : 1'b1;
	// overflow marked in every status byte pushed after the drop, through the frame end
	assign push_ent.status = (rx_accept ? rx_word_status : 8'h00) | ovf_mask;
	wire fe_pushed = rxs_push & push_ent.fe;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxs_cnt <= 2'h0;
			rxs_e0  <= '0;
			rxs_e1  <= '0;
		end else begin
			rxs_cnt <= rx_rst ? 2'h0 : 2'(rxs_slot + {1'b0, rxs_push});
			if (rxs_pop) begin
				rxs_e0 <= rxs_e1;
			end
			if (rxs_push && rxs_slot == 2'h0) begin
				rxs_e0 <= push_ent;
			end
			if (rxs_push && rxs_slot == 2'h1) begin
				rxs_e1 <= push_ent;
			end
		end
	end

	// overflow state per frame, set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_frame     <= 1'b0;
			frame_stored  <= 1'b0;
			rx_overflow   <= 1'b0;
			rx_frame_lost <= 1'b0;
			flush_pend    <= 1'b0;
		end else begin
			ovf_frame <= ~rx_rst & ((rx_drop & ~lost) |
				(ovf_frame & ~fe_pushed & ~lost));
			frame_stored <= ~rx_rst & ~(rx_drop & rx_word_frame_end) &
				((rx_accept & ~rx_word_frame_end) |
				(frame_stored & ~fe_pushed));
			rx_overflow <= rx_drop | (rx_overflow & ~rx_rst);
			rx_frame_lost <= lost;
			// flush requests wait for shadow room
			flush_pend <= cmd_rx_flush | timeout_fire |
				(rx_drop & rx_word_frame_end & frame_stored) |
				(flush_pend & ~mark_in & ~rx_rst);
		end
	end

	// ****************************************************
	// idle timeout
	// ****************************************************
	wire [11:0] idle_limit = {timeout_length, `TIMEOUT_LENGTH_SHIFT};
	// async only, once per idle period
	assign timeout_fire = timeout_enable & async_mode & idle_armed &
		(idle_cnt > idle_limit);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_cnt   <= 12'h000;
			idle_armed <= 1'b0;
		end else begin
			if (rx_in || rx_rst) begin
				idle_cnt <= 12'h000;
			end else if (idle_cnt != 12'hFFF) begin
				idle_cnt <= 12'(idle_cnt + 12'h001);
			end
			idle_armed <= ~rx_rst & (rx_accept | (idle_armed & ~timeout_fire));
		end
	end

	// ****************************************************
	// receive main part
	// ****************************************************
	wire rx_pop = rx_store_pop & (rxm_cnt != 4'h0) & ~rx_rst;
	wire [5:0] bytes_in  = rxs_pop ? 6'(rxs_e0.bytes) : 6'h00;
	wire [5:0] bytes_out = rx_store_valid ? 6'(rx_store_bytes) : 6'h00;
	wire [3:0] next_rxm_cnt = rx_rst ? 4'h0 :
		4'(rxm_cnt + {3'h0, rxs_pop} - {3'h0, rx_pop});
	// full part, threshold level, or frame end
	wire rx_trigger = (rxm_cnt == `RXM_FULL) | (rxm_fe_cnt != 4'h0) |
		(rxm_bytes >= rx_thresh(rx_threshold_field));

	serial_fifo_mem #(.WIDTH($bits(rx_entry_type)), .DEPTH(15), .AW(4))
	rx_main (
		.clk     (pclk),
		.rst_n   (presetn),
		.wr_en   (rxs_pop),
		.wr_addr (rxm_wp),
		.wr_data (rxs_e0),
		.rd_en   (rx_pop),
		.rd_addr (rxm_rp),
		.rd_data (rxm_rd)
	);

	assign rx_store_data      = rxm_rd.data;
	assign rx_store_bytes     = rxm_rd.bytes;
	assign rx_store_frame_end = rxm_rd.fe;
	assign rx_store_status    = rxm_rd.status;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxm_wp         <= 4'h0;
			rxm_rp         <= 4'h0;
			rxm_cnt        <= 4'h0;
			rxm_bytes      <= 6'h00;
			rxm_fe_cnt     <= 4'h0;
			rx_store_valid <= 1'b0;
			rx_store_req   <= 1'b0;
		end else begin
			rxm_cnt        <= next_rxm_cnt;
			rx_store_valid <= rx_pop;
			// request held until the part is drained as one block
			rx_store_req <= (next_rxm_cnt != 4'h0) & (rx_store_req | rx_trigger);
			if (rx_rst) begin
				rxm_wp     <= 4'h0;
				rxm_rp     <= 4'h0;
				rxm_bytes  <= 6'h00;
				rxm_fe_cnt <= 4'h0;
			end else begin
				rxm_bytes  <= 6'(rxm_bytes + bytes_in - bytes_out);
				rxm_fe_cnt <= 4'(rxm_fe_cnt + {3'h0, rxs_pop & rxs_e0.fe} -
					{3'h0, rx_store_valid & rx_store_frame_end});
				if (rxs_pop) begin
					rxm_wp <= ptr_next(rxm_wp, `RXM_LAST);
				end
				if (rx_pop) begin
					rxm_rp <= ptr_next(rxm_rp, `RXM_LAST);
				end
			end
		end
	end
endmodule

// ---- verif/serial_fifo_properties.sv ----
// assertions on the top ports of the serial channel fifos
// assumes a single pclk domain and the shared constants header
`include "serial_fifo_consts.svh"
module serial_fifo_checker (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	// fifo sides
	input wire logic        tx_fetch_req,
	input wire logic        tx_underrun_evt,
	input wire logic        tx_send_allowed,
	input wire logic        tx_start,
	input wire logic        rx_active,
	input wire logic        rx_proto_reset,
	input wire logic        rx_store_req,
	input wire logic        rx_store_pop,
	input wire logic        rx_store_valid
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****************
	// properties
	// ****************
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_cmd(int b);
		psel && penable && pready && pwrite && paddr == `OFF_COMMAND && pwdata[b];
	endsequence
	sequence s_pulse;
		rx_proto_reset ##1 !rx_proto_reset;
	endsequence
	property p_access_once;
		psel && !penable |=> pready ##1 !pready;
	endproperty
	a_access_once: assert property (p_access_once)
		else $error("pready not one access cycle");
	property p_underrun_block;
		tx_underrun_evt |-> ##2 !tx_fetch_req && !tx_start;
	endproperty
	a_underrun_block: assert property (p_underrun_block)
		else $error("transmit still active after underrun");
	property p_start_gate;
		!tx_send_allowed |=> !tx_start;
	endproperty
	a_start_gate: assert property (p_start_gate)
		else $error("send started while not allowed");
	property p_rx_reset;
		s_cmd(`CMD_RX_RESET) |-> ##[1:2] s_pulse;
	endproperty
	a_rx_reset: assert property (p_rx_reset)
		else $error("receive reset pulse missing");
	property p_flush_req;
		s_cmd(`CMD_RX_FLUSH) |-> ##[1:8] rx_store_req;
	endproperty
	a_flush_req: assert property (p_flush_req)
		else $error("flush gave no store request");
	property p_tx_reset;
		s_cmd(`CMD_TX_RESET) |-> ##[1:6] tx_fetch_req;
	endproperty
	a_tx_reset: assert property (p_tx_reset)
		else $error("no fetch request after transmit reset");
	property p_pop_valid;
		rx_store_valid |-> $past(rx_store_pop) && $past(rx_store_req);
	endproperty
	a_pop_valid: assert property (p_pop_valid)
		else $error("store entry without pop");
	property p_rx_active;
		psel && penable && pready && pwrite && paddr == `OFF_CONFIG_2
			|=> rx_active == $past(pwdata[`CFG2_RX_ACTIVE]);
	endproperty
	a_rx_active: assert property (p_rx_active)
		else $error("rx_active does not follow config");
endmodule

bind serial_channel_tx_rx_fifos serial_fifo_checker u_chk (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
	.tx_fetch_req, .tx_underrun_evt, .tx_send_allowed, .tx_start,
	.rx_active, .rx_proto_reset, .rx_store_req, .rx_store_pop,
	.rx_store_valid
);

// ---- verif/central_fifo_model.sv ----
// central transmit and receive fifos as seen by one channel
// assumes the bench stalls it to let the channel fifos fill
module central_fifo_model
	import serial_fifo_pkg::*;
(
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// bench controls
	input  wire logic         stall,
	input  wire logic         feed,
	// transmit side
	input  wire logic         tx_fetch_req,
	output logic              tx_fetch_valid,
	output dword_type         tx_fetch_data,
	// receive side
	input  wire logic         rx_store_req,
	input  wire logic         rx_store_valid,
	input  wire rx_entry_type rx_entry,
	output logic              rx_store_pop
);
	timeunit 1ns;
	timeprecision 100ps;
	dword_type    next_word;
	rx_entry_type got_q[$];
	wire          push = tx_fetch_req && feed && !stall;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_fetch_valid <= 0;
			tx_fetch_data <= '0;
			next_word <= 32'h1000_0000;
			rx_store_pop <= 0;
		end else begin
			tx_fetch_valid <= push;
			// idle data line shows the inverse of its last value, so a stale word returns every second idle cycle
			tx_fetch_data <= push ? next_word : ~tx_fetch_data;
			next_word <= next_word + 32'(push);
			rx_store_pop <= rx_store_req && !stall;
			if (rx_store_valid)
				got_q.push_back(rx_entry);
		end
	end
endmodule

// ---- verif/serial_channel_tx_rx_fifos_tb.sv ----
// self-checking bench for the serial channel fifos
// assumes the checker is bound and the central model stands beside
`include "serial_fifo_consts.svh"
module serial_channel_tx_rx_fifos_tb
	import serial_fifo_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rq;
	logic tx_fetch_req, tx_fetch_valid, tx_clk_present, tx_send_allowed;
	logic tx_underrun_evt, tx_take, tx_start, stall, feed;
	dword_type tx_fetch_data, tx_word, rx_word, rx_store_data;
	logic rx_word_valid, rx_word_frame_end, rx_active, rx_proto_reset;
	logic rx_frame_lost, rx_store_req, rx_store_pop, rx_store_valid;
	logic rx_store_frame_end;
	logic [2:0] rx_word_bytes, rx_store_bytes;
	logic [7:0] rx_word_status, rx_store_status;
	int n_mismatch, cmp_count, rxn, b;
	serial_channel_tx_rx_fifos u_dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_fetch_req,
		.tx_fetch_valid, .tx_fetch_data, .tx_clk_present, .tx_send_allowed,
		.tx_underrun_evt, .tx_take, .tx_word, .tx_start, .rx_word_valid,
		.rx_word, .rx_word_bytes, .rx_word_frame_end, .rx_word_status,
		.rx_active, .rx_proto_reset, .rx_frame_lost, .rx_store_req,
		.rx_store_pop, .rx_store_valid, .rx_store_data, .rx_store_bytes,
		.rx_store_frame_end, .rx_store_status);
	central_fifo_model u_model (.pclk, .presetn, .stall, .feed,
		.tx_fetch_req, .tx_fetch_valid, .tx_fetch_data, .rx_store_req,
		.rx_store_valid, .rx_store_pop, .rx_entry({rx_store_data,
		rx_store_bytes, rx_store_frame_end, rx_store_status}));
	// ****************
	// helpers
	// ****************
	task chk(input logic [31:0] g, input logic [31:0] x);
		cmp_count++;
		if (g !== x) begin
			n_mismatch++;
			$display("Error at %0t: got %h exp %h", $time, g, x);
		end
	endtask
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1);
		rq = prdata;
		re = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task rxw(input logic [2:0] nb, input logic fe);
		@(posedge pclk);
		rx_word_valid <= 1;
		rx_word <= 32'hA000_0000 + rxn;
		rx_word_bytes <= nb;
		rx_word_frame_end <= fe;
		rxn++;
		@(posedge pclk);
		rx_word_valid <= 0;
		rx_word <= ~rx_word;
	endtask
	task wreq;
		for (int k = 0; k < 40 && rx_store_req !== 1; k++) @(posedge pclk);
	endtask
	task drain;
		stall <= 0;
		repeat (8) @(posedge pclk);
		for (int k = 0; k < 80 && rx_store_req !== 0; k++) @(posedge pclk);
		repeat (4) @(posedge pclk);
	endtask
	task take(input dword_type e);
		for (int k = 0; k < 40 && tx_start !== 1; k++) @(posedge pclk);
		chk(tx_word, e);
		tx_take <= 1;
		@(posedge pclk);
		tx_take <= 0;
		@(posedge pclk);
	endtask
	// ****************
	// scenarios
	// ****************
	task t_regs;
		for (int i = 0; i < 5; i++) begin
			bus(0, 12'(4 * i), 0);
			chk(rq, `REG_RESET);
		end
		bus(0, 12'h014, 0);
		chk(rq, `REG_RESET);
		chk(re, 1);
		bus(1, `OFF_STATUS, 32'hFFFF_FFFF);
		bus(0, `OFF_STATUS, 0);
		chk(rq, `REG_RESET);
		$display("regs test done");
	endtask
	task t_tx;
		feed <= 1;
		repeat (20) @(posedge pclk);
		chk(tx_fetch_req, 0);
		bus(0, `OFF_STATUS, 0);
		chk(rq[10:8] > 3'h2, 1);
		chk(tx_start, 0);
		bus(1, `OFF_CONFIG_0, 1);
		repeat (10) @(posedge pclk);
		chk(tx_start, 0);
		tx_clk_present <= 1;
		repeat (10) @(posedge pclk);
		chk(tx_start, 0);
		tx_send_allowed <= 1;
		for (int i = 0; i < 12; i++) take(32'h1000_0000 + i);
		$display("transmit test done");
	endtask
	task t_under;
		dword_type w;
		@(posedge pclk);
		tx_underrun_evt <= 1;
		@(posedge pclk);
		tx_underrun_evt <= 0;
		repeat (3) @(posedge pclk);
		w = tx_word;
		tx_take <= 1;
		@(posedge pclk);
		tx_take <= 0;
		repeat (20) @(posedge pclk);
		chk({tx_fetch_req, tx_start}, 0);
		chk(tx_word, w);
		bus(0, `OFF_STATUS, 0);
		chk(rq[`STAT_TX_UNDER], 1);
		w = u_model.next_word;
		bus(1, `OFF_COMMAND, 32'h0000_0001 << `CMD_TX_RESET);
		take(w);
		bus(0, `OFF_STATUS, 0);
		chk(rq[`STAT_TX_UNDER], 0);
		feed <= 0;
		$display("underrun test done");
	endtask
	task t_thresh;
		int nw[5] = '{8, 4, 2, 1, 1};
		bus(1, `OFF_CONFIG_2, 1);
		stall <= 1;
		repeat (14) rxw(4, 0);
		repeat (6) @(posedge pclk);
		chk(rx_store_req, 0);
		rxw(4, 0);
		wreq;
		chk(rx_store_req, 1);
		b = u_model.got_q.size();
		drain;
		chk(u_model.got_q.size() - b, 15);
		chk(u_model.got_q[$].data, 32'hA000_0000 + rxn - 1);
		for (int c = 1; c < 6; c++) begin
			bus(1, `OFF_CONFIG_2, 32'(1 + (c << `CFG2_RX_THRESHOLD_FIELD_LO)));
			stall <= 1;
			repeat (nw[c - 1] - 1) rxw(4, 0);
			repeat (6) @(posedge pclk);
			chk(rx_store_req, 0);
			rxw((c == 5) ? 3'h1 : 3'h4, 0);
			wreq;
			chk(rx_store_req, 1);
			drain;
		end
		$display("threshold test done");
	endtask
	task t_flush;
		bus(1, `OFF_CONFIG_2, 1);
		bus(0, `OFF_STATUS, 0);
		chk(rq[`STAT_RX_NE], 0);
		b = u_model.got_q.size();
		bus(1, `OFF_COMMAND, 32'h0000_0001 << `CMD_RX_FLUSH);
		drain;
		chk(u_model.got_q.size() - b, 1);
		chk({u_model.got_q[$].fe, u_model.got_q[$].bytes}, 4'h8);
		repeat (2) rxw(4, 0);
		repeat (6) @(posedge pclk);
		bus(0, `OFF_STATUS, 0);
		chk(rq[`STAT_RX_NE], 1);
		bus(1, `OFF_COMMAND, 32'h0000_0001 << `CMD_RX_FLUSH);
		drain;
		chk(u_model.got_q.size() - b, 4);
		chk(u_model.got_q[$].fe, 1);
		$display("flush test done");
	endtask
	task t_ovf;
		stall <= 1;
		b = u_model.got_q.size();
		repeat (18) rxw(4, 0);
		repeat (6) @(posedge pclk);
		bus(0, `OFF_STATUS, 0);
		chk(rq[`STAT_RX_OVF], 1);
		drain;
		rxw(4, 1);
		drain;
		chk(u_model.got_q.size() - b, 18);
		chk(u_model.got_q[$].status[`RX_STATUS_BYTE_OVF_BIT], 1);
		rxw(4, 1);
		drain;
		chk(u_model.got_q[$].status[`RX_STATUS_BYTE_OVF_BIT], 0);
		// whole frames only: the eighteenth is dropped entirely
		stall <= 1;
		repeat (18) rxw(4, 1);
		@(posedge pclk);
		chk(rx_frame_lost, 1);
		drain;
		$display("overflow test done");
	endtask
	task t_rxrst;
		repeat (2) rxw(4, 0);
		bus(1, `OFF_CONFIG_2, 0);
		@(posedge pclk);
		chk(rx_active, 0);
		rxw(4, 0);
		bus(1, `OFF_COMMAND, 32'h0000_0001 << `CMD_RX_RESET);
		bus(0, `OFF_STATUS, 0);
		chk(rq[`STAT_RX_NE], 0);
		chk(rq[`STAT_RX_OVF], 0);
		b = u_model.got_q.size();
		bus(1, `OFF_COMMAND, 32'h0000_0001 << `CMD_RX_FLUSH);
		drain;
		chk(u_model.got_q.size() - b, 1);
		chk(u_model.got_q[$].bytes, 0);
		bus(1, `OFF_CONFIG_2, 1);
		@(posedge pclk);
		chk(rx_active, 1);
		$display("receive reset test done");
	endtask
	task t_timeout;
		bus(1, `OFF_CONFIG_1, 32'h0000_0101);
		bus(1, `OFF_CONFIG_2, 32'h0000_0003);
		stall <= 1;
		rxw(4, 0);
		repeat (10) @(posedge pclk);
		chk(rx_store_req, 0);
		wreq;
		chk(rx_store_req, 1);
		drain;
		chk(u_model.got_q[$].fe, 1);
		$display("timeout test done");
	endtask
	task summarize;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ****************
	// run control
	// ****************
	initial begin
		pclk = 0;
		forever #12.5 pclk = ~pclk;
	end
	initial begin
		#250000;
		n_mismatch++;
		summarize;
	end
	initial begin
		{psel, penable, pwrite, tx_clk_present, tx_send_allowed} = '0;
		{tx_underrun_evt, tx_take, rx_word_valid, rx_word_frame_end} = '0;
		{stall, feed, paddr, pwdata, rx_word} = '0;
		{rx_word_bytes, rx_word_status} = '0;
		{presetn, n_mismatch, cmp_count, rxn} = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		t_regs;
		t_tx;
		t_under;
		t_thresh;
		t_flush;
		t_ovf;
		t_rxrst;
		t_timeout;
		summarize;
	end
endmodule
